// [logic/clock_control_defs.vh]
`ifndef CLOCK_CONTROL_DEFS_VH
`define CLOCK_CONTROL_DEFS_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define ADDR_TRIM        12'h000
`define ADDR_OSC_CTRL    12'h004
`define ADDR_CONFIG      12'h008
`define ADDR_STATUS      12'h00C
`define ADDR_FEATURES    12'h010

// ----------------------------------------------------------------
// trim register fields
// ----------------------------------------------------------------
`define TRIM_TUNE_MSB    5
`define TRIM_MULT_ON     6
`define TRIM_LOW_ORIGIN  7
`define TRIM_RESET       8'h00

// ----------------------------------------------------------------
// oscillator control register fields
// ----------------------------------------------------------------
`define OCTRL_FREQ_LSB   4
`define OCTRL_FREQ_MSB   6
`define OCTRL_RESET      8'h60
`define FREQ_LOWEST      3'h0
`define FREQ_FAST_DIRECT 3'h7

// ----------------------------------------------------------------
// configuration word fields
// ----------------------------------------------------------------
`define CFG_MODE_MSB     2
`define CFG_MULT_OFF     4
`define CFG_DIV_LSB      5
`define CFG_DIV_MSB      6
`define CFG_MULT_CHOICE  10
`define CFG_PRESCALE_LSB 12
`define CFG_PRESCALE_MSB 14
`define CFG_RESET        32'h0000_0017

// ----------------------------------------------------------------
// oscillator modes
// ----------------------------------------------------------------
`define MODE_INT_PLAIN   3'h0
`define MODE_INT_CLKOUT  3'h1
`define MODE_INT_MULT    3'h2
`define MODE_INT_MULT_CO 3'h3
`define MODE_XTAL        3'h4
`define MODE_XTAL_MULT   3'h5
`define MODE_EXT         3'h6
`define MODE_EXT_MULT    3'h7

// ----------------------------------------------------------------
// clock source codes on the status register
// ----------------------------------------------------------------
`define SRC_PRIMARY      3'h0
`define SRC_MULT         3'h1
`define SRC_FAST_INT     3'h2
`define SRC_POSTSCALED   3'h3
`define SRC_SLOW_RC      3'h4

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_HZ           20000000
`define TRIM_SETTLE_NS   1000
`define TRIM_SETTLE_CYC  ((`TRIM_SETTLE_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define LOCK_CYCLES      16'h0064
`define AXI_OKAY         2'h0
`define AXI_DECERR       2'h3

`endif

// [logic/clock_divider.v]
`timescale 1ns/1ps
// divides a rate-enable by 1..256, one pulse per n input pulses
module clock_divider (
  // clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // control
  input  wire       tick_in,
  input  wire [7:0] ratio_m1,
  // result
  output reg        tick_out
);

  reg [7:0] count_reg;

  always @(posedge clk) begin
    if (!rst_n) begin
      count_reg <= 8'h00;
      tick_out  <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (tick_in) begin
        if (count_reg >= ratio_m1) begin
          count_reg <= 8'h00;
          tick_out  <= 1'b1;
        end else begin
          count_reg <= count_reg + 8'h01;
        end
      end
    end
  end

endmodule

// [logic/mult_lock_timer.v]
`timescale 1ns/1ps
// counts lock cycles after the multiplier is enabled; ready drops when disabled
module mult_lock_timer (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // control
  input  wire        enable,
  input  wire [15:0] lock_cycles,
  // status
  output reg         ready
);

  reg [15:0] count_reg;

  always @(posedge clk) begin
    if (!rst_n) begin
      count_reg <= 16'h0000;
      ready     <= 1'b0;
    end else if (!enable) begin
      count_reg <= 16'h0000;
      ready     <= 1'b0;
    end else if (count_reg >= lock_cycles) begin
      ready <= 1'b1;
    end else begin
      count_reg <= count_reg + 16'h0001;
    end
  end

endmodule

// [logic/clock_source_pll_control.v]
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module clock_source_pll_control (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // axi4-lite write address
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // clock source rate ticks (one per source clock period, scaled)
  input  wire        src_tick,
  // core clock as a rate enable; clock out as a level that toggles every two selected ticks, with its enable
  output reg         core_tick,
  output reg         clock_out_pin,
  output reg         clock_out_en,
  // oscillator controls
  output reg         mult_enable,
  output reg         mult_is_fixed,
  output reg         slow_rc_enable,
  output reg         fast_osc_enable,
  output reg  [2:0]  active_source
);

`include "clock_control_defs.vh"

  localparam [15:0] LOCK_CYCLES = `LOCK_CYCLES;
  localparam integer SETTLE_FULL = `TRIM_SETTLE_CYC;
  localparam [7:0]  SETTLE_CYC  = SETTLE_FULL[7:0];

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  reg  [7:0]  oscillator_trim_reg;
  reg  [7:0]  oscillator_ctrl_reg;
  reg  [31:0] config_reg;
  reg  [3:0]  feature_reg;
  reg  [7:0]  settle_reg;
  reg  [1:0]  src_sync_reg;

  wire [2:0] oscillator_mode_fuses = config_reg[`CFG_MODE_MSB:0];
  wire       multiplier_off_fuse   = config_reg[`CFG_MULT_OFF];
  wire [1:0] core_divider          = config_reg[`CFG_DIV_MSB:`CFG_DIV_LSB];
  wire       multiplier_choice     = config_reg[`CFG_MULT_CHOICE];
  wire [2:0] prescale_sel          = config_reg[`CFG_PRESCALE_MSB:`CFG_PRESCALE_LSB];
  wire       multiplier_on_bit     = oscillator_trim_reg[`TRIM_MULT_ON];
  wire       low_freq_origin_bit   = oscillator_trim_reg[`TRIM_LOW_ORIGIN];
  wire [2:0] internal_freq_choice  = oscillator_ctrl_reg[`OCTRL_FREQ_MSB:`OCTRL_FREQ_LSB];

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function mode_has_mult;
    input [2:0] m;
    begin
      mode_has_mult = (m == `MODE_INT_MULT) || (m == `MODE_INT_MULT_CO) ||
                      (m == `MODE_XTAL_MULT) || (m == `MODE_EXT_MULT);
    end
  endfunction

  function mode_is_ext;
    input [2:0] m;
    begin
      mode_is_ext = (m == `MODE_EXT) || (m == `MODE_EXT_MULT);
    end
  endfunction

  // prescaler ratio minus one for source 4..48 MHz
  function [7:0] prescale_m1;
    input [2:0] s;
    begin
      case (s)
        3'h0: prescale_m1 = 8'h00;
        3'h1: prescale_m1 = 8'h01;
        3'h2: prescale_m1 = 8'h02;
        3'h3: prescale_m1 = 8'h03;
        3'h4: prescale_m1 = 8'h04;
        3'h5: prescale_m1 = 8'h05;
        3'h6: prescale_m1 = 8'h09;
        default: prescale_m1 = 8'h0B;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // source tick synchroniser
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      src_sync_reg <= 2'b00;
    end else begin
      src_sync_reg <= {src_sync_reg[0], src_tick};
    end
  end

  reg src_prev_reg;
  always @(posedge clk) begin
    if (!rst_n) begin
      src_prev_reg <= 1'b0;
    end else begin
      src_prev_reg <= src_sync_reg[1];
    end
  end
  wire src_edge = src_sync_reg[1] & ~src_prev_reg;

  // ----------------------------------------------------------------
  // multiplier enable and lock
  // ----------------------------------------------------------------
  wire mult_want = mode_has_mult(oscillator_mode_fuses) &&
                   (multiplier_on_bit || !multiplier_off_fuse);
  wire mult_ready;

  mult_lock_timer u_lock (
    .clk         (clk),
    .rst_n       (rst_n),
    .enable      (mult_want),
    .lock_cycles (LOCK_CYCLES),
    .ready       (mult_ready)
  );

  // fixed path: prescale source to 4 MHz, x24 to 96 MHz, /2 gives 48 MHz
  // 4x path: four output ticks per input tick, modelled by scaling the rate
  wire pre_tick;
  clock_divider u_pre (
    .clk      (clk),
    .rst_n    (rst_n),
    .tick_in  (src_edge),
    .ratio_m1 (prescale_m1(prescale_sel)),
    .tick_out (pre_tick)
  );

  reg [3:0] burst_reg;
  always @(posedge clk) begin
    if (!rst_n) begin
      burst_reg <= 4'h0;
    end else if (multiplier_choice ? pre_tick : src_edge) begin
      burst_reg <= multiplier_choice ? 4'hC : 4'h4; // 48/4 = 12, or 4x
    end else if (burst_reg != 4'h0) begin
      burst_reg <= burst_reg - 4'h1;
    end
  end
  wire mult_tick = mult_ready && (burst_reg != 4'h0);

  // ----------------------------------------------------------------
  // source selection, switched only on a source tick boundary
  // ----------------------------------------------------------------
  reg [2:0] src_next;
  always @* begin
    src_next = `SRC_PRIMARY;
    if (oscillator_mode_fuses < `MODE_XTAL) begin
      if (internal_freq_choice == `FREQ_FAST_DIRECT) begin
        src_next = `SRC_FAST_INT;
      end else if (internal_freq_choice == `FREQ_LOWEST && !low_freq_origin_bit) begin
        src_next = `SRC_SLOW_RC;
      end else begin
        src_next = `SRC_POSTSCALED;
      end
    end
    if (mult_want && mult_ready) begin
      src_next = `SRC_MULT;
    end
  end

  // postscaler ratio over the 8 MHz rate, lowest is divide by 256
  reg [7:0] post_m1;
  always @* begin
    case (internal_freq_choice)
      3'h0: post_m1 = 8'hFF;
      3'h1: post_m1 = 8'h7F;
      3'h2: post_m1 = 8'h3F;
      3'h3: post_m1 = 8'h1F;
      3'h4: post_m1 = 8'h07;
      3'h5: post_m1 = 8'h03;
      3'h6: post_m1 = 8'h01;
      default: post_m1 = 8'h00;
    endcase
  end

  wire post_tick;
  clock_divider u_post (
    .clk      (clk),
    .rst_n    (rst_n),
    .tick_in  (src_edge),
    .ratio_m1 (post_m1),
    .tick_out (post_tick)
  );

  // the switch waits for a tick so no partial period reaches the core
  wire any_tick = src_edge | mult_tick;
  always @(posedge clk) begin
    if (!rst_n) begin
      active_source <= `SRC_PRIMARY;
    end else if (any_tick || active_source == src_next) begin
      active_source <= src_next;
    end
  end

  reg sel_tick;
  always @* begin
    case (active_source)
      `SRC_MULT:       sel_tick = mult_tick;
      `SRC_POSTSCALED: sel_tick = post_tick;
      default:         sel_tick = src_edge;
    endcase
  end

  // ----------------------------------------------------------------
  // core divider and clock out
  // ----------------------------------------------------------------
  reg [2:0] core_cnt_reg;
  reg [1:0] out_cnt_reg;
  wire [2:0] core_m1 = (core_divider == 2'h0) ? 3'h0 :
                       (core_divider == 2'h1) ? 3'h1 :
                       (core_divider == 2'h2) ? 3'h2 : 3'h5;

  always @(posedge clk) begin
    if (!rst_n) begin
      core_cnt_reg  <= 3'h0;
      out_cnt_reg   <= 2'h0;
      core_tick     <= 1'b0;
      clock_out_pin <= 1'b0;
      clock_out_en  <= 1'b0;
    end else begin
      core_tick <= 1'b0;
      if (sel_tick) begin
        if (core_cnt_reg >= core_m1) begin
          core_cnt_reg <= 3'h0;
          core_tick    <= 1'b1;
        end else begin
          core_cnt_reg <= core_cnt_reg + 3'h1;
        end
        out_cnt_reg <= out_cnt_reg + 2'h1;
        if (out_cnt_reg == 2'h1 || out_cnt_reg == 2'h3) begin
          clock_out_pin <= ~clock_out_pin;
        end
      end
      clock_out_en <= mode_is_ext(oscillator_mode_fuses) ||
                      oscillator_mode_fuses == `MODE_INT_CLKOUT ||
                      oscillator_mode_fuses == `MODE_INT_MULT_CO;
    end
  end

  // ----------------------------------------------------------------
  // oscillator enables
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      mult_enable     <= 1'b0;
      mult_is_fixed   <= 1'b0;
      slow_rc_enable  <= 1'b1;
      fast_osc_enable <= 1'b1;
    end else begin
      mult_enable     <= mult_want;
      mult_is_fixed   <= multiplier_choice;
      // the core still runs from it until the switch lands on a tick
      slow_rc_enable  <= (src_next == `SRC_SLOW_RC) || (active_source == `SRC_SLOW_RC) ||
                         (feature_reg != 4'h0);
      fast_osc_enable <= oscillator_mode_fuses < `MODE_XTAL;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  reg        aw_held_reg;
  reg        w_held_reg;
  reg [11:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0]  wstrb_reg;
  wire       do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always @(posedge clk) begin
    if (!rst_n) begin
      aw_held_reg         <= 1'b0;
      w_held_reg          <= 1'b0;
      awaddr_reg          <= 12'h000;
      wdata_reg           <= 32'h0000_0000;
      wstrb_reg           <= 4'h0;
      s_axi_awready       <= 1'b0;
      s_axi_wready        <= 1'b0;
      s_axi_bvalid        <= 1'b0;
      s_axi_bresp         <= `AXI_OKAY;
      oscillator_trim_reg <= `TRIM_RESET;
      oscillator_ctrl_reg <= `OCTRL_RESET;
      config_reg          <= `CFG_RESET;
      feature_reg         <= 4'h0;
      settle_reg          <= 8'h00;
    end else begin
      s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awready && s_axi_awvalid) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (settle_reg != 8'h00) begin
        settle_reg <= settle_reg - 8'h01;
      end
      if (do_write) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `AXI_OKAY;
        if (awaddr_reg == `ADDR_TRIM) begin
          if (wstrb_reg[0]) begin
            oscillator_trim_reg <= wdata_reg[7:0];
            settle_reg          <= SETTLE_CYC;
          end
        end else if (awaddr_reg == `ADDR_OSC_CTRL) begin
          if (wstrb_reg[0]) oscillator_ctrl_reg <= wdata_reg[7:0];
        end else if (awaddr_reg == `ADDR_CONFIG) begin
          if (wstrb_reg[0]) config_reg[7:0]   <= wdata_reg[7:0];
          if (wstrb_reg[1]) config_reg[15:8]  <= wdata_reg[15:8];
          if (wstrb_reg[2]) config_reg[23:16] <= wdata_reg[23:16];
          if (wstrb_reg[3]) config_reg[31:24] <= wdata_reg[31:24];
        end else if (awaddr_reg == `ADDR_FEATURES) begin
          if (wstrb_reg[0]) feature_reg <= wdata_reg[3:0];
        end else if (awaddr_reg != `ADDR_STATUS) begin
          s_axi_bresp <= `AXI_DECERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // the settle counter is internal only: no completion is ever reported
  always @(posedge clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `AXI_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `AXI_OKAY;
        if (s_axi_araddr == `ADDR_TRIM) begin
          s_axi_rdata <= {24'h00_0000, oscillator_trim_reg};
        end else if (s_axi_araddr == `ADDR_OSC_CTRL) begin
          s_axi_rdata <= {24'h00_0000, oscillator_ctrl_reg};
        end else if (s_axi_araddr == `ADDR_CONFIG) begin
          s_axi_rdata <= config_reg;
        end else if (s_axi_araddr == `ADDR_STATUS) begin
          s_axi_rdata <= {26'h000_0000, mult_ready, mult_enable, 1'b0, active_source};
        end else if (s_axi_araddr == `ADDR_FEATURES) begin
          s_axi_rdata <= {28'h000_0000, feature_reg};
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `AXI_DECERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// [verification/ext_clock_source.sv]
`timescale 1ns/1ps
// ----------------------------------------
// external clock applied to the clock input
// ----------------------------------------
module ext_clock_source (
  // clock
  input  wire logic       clk,
  // half period in bench clock cycles
  input  wire logic [7:0] half,
  // clock to the block
  output logic            src_tick
);
  logic [7:0] cnt_reg;

  initial begin
    cnt_reg = 8'h00;
    src_tick = 1'b0;
  end

  // a driven clock needs no start-up, so it toggles from time zero
  always @(posedge clk) begin
    if (cnt_reg + 8'h01 >= half) begin
      cnt_reg <= 8'h00;
      src_tick <= ~src_tick;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
endmodule

// [verification/clock_source_pll_control_sva.sv]
`timescale 1ns/1ps
`include "clock_control_defs.vh"
module clock_source_pll_control_sva (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // clock control
  input wire logic        mult_enable,
  input wire logic        slow_rc_enable,
  input wire logic        fast_osc_enable,
  input wire logic [2:0]  active_source
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------
  // cycles the multiplier has been enabled
  // ----------------------------------------
  logic [15:0] on_cnt;
  always @(posedge clk) begin
    if (!rst_n || !mult_enable) begin
      on_cnt <= 16'h0000;
    end else if (on_cnt != 16'hffff) begin
      on_cnt <= on_cnt + 16'h0001;
    end
  end

  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_aw_pulse: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("write address taken twice");
  a_ar_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  // leaving the multiplier waits for a source tick, so only the entry is bound to lock
  wire on_mult = (active_source == `SRC_MULT);

  a_lock_wait: assert property ($rose(on_mult) |-> on_cnt >= `LOCK_CYCLES)
    else $error("switched before lock");
  a_mult_leave: assert property ($fell(mult_enable) |-> ##[0:520] active_source != `SRC_MULT)
    else $error("still on multiplier after disable");
  a_rc_chosen: assert property (active_source == `SRC_SLOW_RC |-> slow_rc_enable)
    else $error("slow oscillator off while chosen");
  a_fast_chosen: assert property (active_source == `SRC_FAST_INT |-> fast_osc_enable)
    else $error("fast oscillator off while chosen");
  a_reset_state: assert property ($rose(rst_n) |-> !mult_enable && active_source == 3'h0)
    else $error("wrong state after reset");

  c_lock: cover property ($rose(active_source == `SRC_MULT));
  c_decerr: cover property (s_axi_bvalid && s_axi_bresp == `AXI_DECERR);
  c_slow: cover property (active_source == `SRC_SLOW_RC);
endmodule

bind clock_source_pll_control clock_source_pll_control_sva chk_i (.*);

// [verification/tb_clock_source_pll_control.sv]
`timescale 1ns/1ps
`include "clock_control_defs.vh"
module tb_clock_source_pll_control;
  logic        clk, rst_n, src_tick, core_tick, clock_out_pin, clock_out_en;
  logic        mult_enable, mult_is_fixed, slow_rc_enable, fast_osc_enable;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [2:0]  active_source;
  logic [7:0]  half;
  int          num_errors, total_checks, g;
  localparam logic [31:0] zero = 32'h0000_0000;

  clock_source_pll_control uut (.*);
  ext_clock_source src_i (.clk(clk), .half(half), .src_tick(src_tick));

  always #25 clk = ~clk;

  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d, input int lag, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (lag == 0);
    while (!(s_axi_bvalid && s_axi_bready) && n < 300) begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && !s_axi_bready) begin
        if (lag == 0) s_axi_bready <= 1'b1;
        else lag--;
      end
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask

  task rd_reg(input logic [11:0] a, input int lag, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (lag == 0);
    while (!(s_axi_rvalid && s_axi_rready) && n < 300) begin
      @(posedge clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready) begin
        if (lag == 0) s_axi_rready <= 1'b1;
        else lag--;
      end
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask

  // registered outputs settle a few cycles after the write response
  task w(input logic [11:0] a, input logic [31:0] d);
    wr(a, d, 0, rs);
    chk(rs, `AXI_OKAY);
    repeat (3) @(posedge clk);
  endtask

  task rc(input logic [11:0] a, input logic [31:0] e);
    rd_reg(a, 0, rd, rs);
    chk(rd, e);
    chk(rs, `AXI_OKAY);
  endtask

  // mean period over twelve events after thirteen settling ones; multiplier ticks come in bursts
  task per(input bit sel, input int e);
    int k;
    logic p, c;
    k = -13;
    g = 0;
    p = 1'b1;
    for (int i = 0; i < 2000 && k < 12; i++) begin
      @(posedge clk);
      c = sel ? clock_out_pin : core_tick;
      if (k >= 0) g++;
      if (c === 1'b1 && (!sel || p === 1'b0)) k++;
      p = c;
    end
    chk(g, 12 * e);
  endtask

  // the source only switches on a tick, and to the multiplier only after lock
  task src_is(input logic [2:0] e);
    for (int i = 0; i < 400 && active_source !== e; i++) @(posedge clk);
    chk(active_source, e);
  endtask

  task do_reset;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset_values;
    rc(`ADDR_TRIM, zero);
    rc(`ADDR_OSC_CTRL, 32'h0000_0060);
    rc(`ADDR_CONFIG, 32'h0000_0017);
    rc(`ADDR_STATUS, zero);
    rd_reg(12'h020, 2, rd, rs);
    chk(rd, zero);
    chk(rs, `AXI_DECERR);
    wr(12'h020, 32'hffff_ffff, 2, rs);
    chk(rs, `AXI_DECERR);
    w(`ADDR_STATUS, 32'h0000_00ff);
    rc(`ADDR_STATUS, zero);
  endtask

  task t_modes;
    w(`ADDR_TRIM, 32'h0000_0040);
    for (int m = 0; m < 8; m++) begin
      w(`ADDR_CONFIG, 32'h0000_0010 + m);
      chk(mult_enable, 8'hac >> m & 1);
      chk(clock_out_en, 8'hca >> m & 1);
      chk(fast_osc_enable, 8'h0f >> m & 1);
    end
  endtask

  task t_divider;
    w(`ADDR_TRIM, zero);
    for (int d = 0; d < 4; d++) begin
      w(`ADDR_CONFIG, 32'h0000_0016 + (d << 5));
      per(0, 8 * (d == 3 ? 6 : d + 1));
    end
    per(1, 32);
  endtask

  task t_multiplier;
    half <= 8'h08;
    w(`ADDR_CONFIG, 32'h0000_0017);
    w(`ADDR_TRIM, 32'h0000_0040);
    chk({mult_enable, active_source}, {1'b1, `SRC_PRIMARY});
    chk(mult_is_fixed, 1'b0);
    src_is(`SRC_MULT);
    per(0, 4);
    per(1, 16);
    w(`ADDR_CONFIG, 32'h0000_2417);
    chk(mult_is_fixed, 1'b1);
    per(0, 4);
    w(`ADDR_CONFIG, 32'h0000_7417);
    per(0, 16);
    w(`ADDR_TRIM, zero);
    src_is(`SRC_PRIMARY);
    chk(mult_enable, 1'b0);
    w(`ADDR_CONFIG, 32'h0000_0007);
    chk(mult_enable, 1'b1);
    w(`ADDR_CONFIG, 32'h0000_0006);
    chk(mult_enable, 1'b0);
    half <= 8'h04;
  endtask

  task t_internal;
    w(`ADDR_CONFIG, 32'h0000_0010);
    w(`ADDR_OSC_CTRL, 32'h0000_0070);
    src_is(`SRC_FAST_INT);
    w(`ADDR_OSC_CTRL, 32'h0000_0030);
    src_is(`SRC_POSTSCALED);
    w(`ADDR_OSC_CTRL, zero);
    src_is(`SRC_SLOW_RC);
    chk(slow_rc_enable, 1'b1);
    w(`ADDR_TRIM, 32'h0000_0080);
    src_is(`SRC_POSTSCALED);
  endtask

  task t_slow_rc;
    w(`ADDR_TRIM, zero);
    w(`ADDR_CONFIG, 32'h0000_0016);
    w(`ADDR_FEATURES, zero);
    chk(slow_rc_enable, 1'b0);
    for (int b = 0; b < 4; b++) begin
      w(`ADDR_FEATURES, 1 << b);
      chk(slow_rc_enable, 1'b1);
    end
  endtask

  task t_trim_reset;
    w(`ADDR_TRIM, 32'h0000_003f);
    rc(`ADDR_TRIM, 32'h0000_003f);
    do_reset;
    rc(`ADDR_CONFIG, 32'h0000_0017);
    rc(`ADDR_TRIM, zero);
  endtask

  task end_of_test;
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    half = 8'h04;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    num_errors = 0;
    total_checks = 0;
    do_reset;
    t_reset_values;
    t_modes;
    t_divider;
    t_multiplier;
    t_internal;
    t_slow_rc;
    t_trim_reset;
    end_of_test;
  end

  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    end_of_test;
  end
endmodule
